// ===== core/fidl_pkg.sv
// Purpose: shared constants for the fault indicator block
// Assumes: 100 MHz system clock
// Notes: fault flag bit positions equal the indicator codes
package fidl_pkg;
  // -----------------------------------------------------------------
  // fault flag positions (bit index = flash code)
  // -----------------------------------------------------------------
  localparam int FLT_W = 16;
  localparam int CODE_W = 4;
  localparam int F_DATA_MEM = 0;
  localparam int F_PROG_MEM = 1;
  localparam int F_CFG_MEM = 2;
  localparam int F_OTHER_MEM = 3;
  localparam int F_MICROWAVE = 4;
  localparam int F_DISPLAY = 5;
  localparam int F_MODEM = 6;
  localparam int F_ANALOG_OUT = 7;
  localparam int F_INT_TEMP = 8;
  localparam int F_UNSPEC_HW = 11;
  localparam int F_MEASURE = 12;
  localparam int F_CFG_RANGE = 14;
  localparam int F_SOFTWARE = 15;
  // codes that may light the LED; 3, 9, 10, 13 never flash
  localparam logic [FLT_W-1:0] LED_CODE_MASK = 16'hD9F7;
  // -----------------------------------------------------------------
  // display message numbers
  // -----------------------------------------------------------------
  localparam logic [3:0] MSG_NONE = 4'h0;
  localparam logic [3:0] MSG_DATA_MEM = 4'h1;
  localparam logic [3:0] MSG_PROG_MEM = 4'h2;
  localparam logic [3:0] MSG_CFG_MEM = 4'h3;
  localparam logic [3:0] MSG_OTHER_MEM = 4'h4;
  localparam logic [3:0] MSG_MICROWAVE = 4'h5;
  localparam logic [3:0] MSG_DISPLAY = 4'h6;
  localparam logic [3:0] MSG_MODEM = 4'h7;
  localparam logic [3:0] MSG_ANALOG_OUT = 4'h8;
  localparam logic [3:0] MSG_UNSPEC_HW = 4'h9;
  localparam logic [3:0] MSG_INT_TEMP = 4'hA;
  localparam logic [3:0] MSG_MEASURE = 4'hB;
  localparam logic [3:0] MSG_CFG_RANGE = 4'hC;
  localparam logic [3:0] MSG_SOFTWARE = 4'hD;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam longint CLK_HZ = 100000000;
  localparam int IDLE_PERIOD_MS = 2000;
  localparam int PAUSE_MS = 5000;
  localparam int FLASH_ON_MS = 250;
  localparam int FLASH_OFF_MS = 250;
  localparam int VAR_PERIOD_MS = 2000;
  localparam int RESET_PULSE_CYC = 16;
  localparam longint IDLE_CYC = CLK_HZ / 1000 * IDLE_PERIOD_MS;
  localparam longint PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;
  localparam longint FLASH_ON_CYC = CLK_HZ / 1000 * FLASH_ON_MS;
  localparam longint FLASH_OFF_CYC = CLK_HZ / 1000 * FLASH_OFF_MS;
  localparam longint VAR_CYC = CLK_HZ / 1000 * VAR_PERIOD_MS;
endpackage

// ===== core/fidl_flasher.sv
// Purpose: counted flash pattern generator for the status LED
// Assumes: code and start come from logic on the same clock
// Notes: code 0 still flashes once, so no-fault and code 0 look alike in count
`timescale 1ns/1ps
module fidl_flasher #(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] ON_CYC = CNT_W'(fidl_pkg::FLASH_ON_CYC),
  parameter logic [CNT_W-1:0] OFF_CYC = CNT_W'(fidl_pkg::FLASH_OFF_CYC)
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [4:0] count_i,
  output logic led_o,
  output logic busy_o
);
  typedef enum logic [1:0] {FL_IDLE, FL_ON, FL_OFF} fidl_fl_state_type;
  fidl_fl_state_type state_ff;
  logic [CNT_W-1:0] tmr_ff;
  logic [4:0] left_ff;

  // -----------------------------------------------------------------
  // flash sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_ff <= FL_IDLE;
      tmr_ff <= '0;
      left_ff <= '0;
    end else begin
      case (state_ff)
        FL_IDLE: begin
          if (start_i) begin
            state_ff <= FL_ON;
            tmr_ff <= ON_CYC - CNT_W'(1);
            left_ff <= count_i;
          end
        end
        FL_ON: begin
          if (tmr_ff == '0) begin
            state_ff <= FL_OFF;
            tmr_ff <= OFF_CYC - CNT_W'(1);
          end else begin
            tmr_ff <= tmr_ff - CNT_W'(1);
          end
        end
        FL_OFF: begin
          if (tmr_ff != '0) begin
            tmr_ff <= tmr_ff - CNT_W'(1);
          end else if (left_ff > 5'h01) begin
            left_ff <= left_ff - 5'h01;
            state_ff <= FL_ON;
            tmr_ff <= ON_CYC - CNT_W'(1);
          end else begin
            state_ff <= FL_IDLE;
          end
        end
        default: state_ff <= FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      led_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      led_o <= (state_ff == FL_ON);
      busy_o <= (state_ff != FL_IDLE) || start_i;
    end
  end
endmodule // fidl_flasher

// ===== core/fidl_fault_indicator.sv
// Purpose: fault code selection, LED flash pattern, display message and self-test responses
// Assumes: fault flags are synchronous to clk_sys_i; straps may be asynchronous
// Notes: display text itself is rendered by the display driver from msg_o
`timescale 1ns/1ps
module fidl_fault_indicator #(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] IDLE_CYC = CNT_W'(fidl_pkg::IDLE_CYC),
  parameter logic [CNT_W-1:0] PAUSE_CYC = CNT_W'(fidl_pkg::PAUSE_CYC),
  parameter logic [CNT_W-1:0] FLASH_ON_CYC = CNT_W'(fidl_pkg::FLASH_ON_CYC),
  parameter logic [CNT_W-1:0] FLASH_OFF_CYC = CNT_W'(fidl_pkg::FLASH_OFF_CYC),
  parameter logic [CNT_W-1:0] VAR_CYC = CNT_W'(fidl_pkg::VAR_CYC),
  parameter int NUM_VARS = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic has_display_i,
  input wire logic [fidl_pkg::FLT_W-1:0] fault_i,
  input wire logic data_mem_test_err_i,
  input wire logic prog_mem_test_err_i,
  input wire logic cfg_mem_err_i,
  input wire logic cfg_range_err_i,
  input wire logic [7:0] var_sel_mask_i,
  output logic led_orange_o,
  output logic [3:0] msg_o,
  output logic [fidl_pkg::FLT_W-1:0] fault_flags_o,
  output logic self_reset_o,
  output logic use_defaults_o,
  output logic [3:0] var_idx_o
);
  typedef enum logic [1:0] {SQ_START, SQ_FLASH, SQ_GAP} fidl_seq_state_type;

  // -----------------------------------------------------------------
  // strap synchroniser
  // -----------------------------------------------------------------
  logic disp_meta_ff;
  logic disp_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      disp_meta_ff <= 1'b0;
      disp_ff <= 1'b0;
    end else begin
      disp_meta_ff <= has_display_i;
      disp_ff <= disp_meta_ff;
    end
  end

  // -----------------------------------------------------------------
  // fault flag merge
  // -----------------------------------------------------------------
  logic [fidl_pkg::FLT_W-1:0] nxt_flags;
  always_comb begin
    nxt_flags = fault_i & fidl_pkg::LED_CODE_MASK;
    nxt_flags[fidl_pkg::F_OTHER_MEM] = fault_i[fidl_pkg::F_OTHER_MEM];
    nxt_flags[fidl_pkg::F_DATA_MEM] = fault_i[fidl_pkg::F_DATA_MEM] | data_mem_test_err_i;
    nxt_flags[fidl_pkg::F_PROG_MEM] = fault_i[fidl_pkg::F_PROG_MEM] | prog_mem_test_err_i;
    nxt_flags[fidl_pkg::F_CFG_MEM] = fault_i[fidl_pkg::F_CFG_MEM] | cfg_mem_err_i;
    nxt_flags[fidl_pkg::F_CFG_RANGE] = fault_i[fidl_pkg::F_CFG_RANGE] | cfg_range_err_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_flags_o <= '0;
      use_defaults_o <= 1'b0;
    end else begin
      fault_flags_o <= nxt_flags;
      // defaults held while either config fault persists
      use_defaults_o <= cfg_mem_err_i | cfg_range_err_i;
    end
  end

  // -----------------------------------------------------------------
  // startup memory test: flag first, then request reset
  // -----------------------------------------------------------------
  logic rst_arm_ff;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_arm_ff <= 1'b0;
      self_reset_o <= 1'b0;
    end else begin
      if (!rst_arm_ff && (data_mem_test_err_i || prog_mem_test_err_i)) begin
        rst_arm_ff <= 1'b1;
      end
      // flag is visible for one clock cycle before reset asserts
      self_reset_o <= rst_arm_ff;
    end
  end

  // -----------------------------------------------------------------
  // lowest active code
  // -----------------------------------------------------------------
  logic any_fault;
  logic [fidl_pkg::CODE_W-1:0] low_code;
  logic [fidl_pkg::FLT_W-1:0] led_faults;
  always_comb begin
    led_faults = fault_flags_o & fidl_pkg::LED_CODE_MASK;
    any_fault = |led_faults;
    low_code = '0;
    for (int i = fidl_pkg::FLT_W - 1; i >= 0; i--) begin
      if (led_faults[i]) begin
        low_code = fidl_pkg::CODE_W'(i);
      end
    end
  end

  // -----------------------------------------------------------------
  // LED sequencer
  // -----------------------------------------------------------------
  fidl_seq_state_type seq_ff;
  logic [CNT_W-1:0] gap_ff;
  logic [4:0] flash_cnt_ff;
  logic gap_is_pause_ff;
  logic fl_start_ff;
  logic fl_led;
  logic fl_busy;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      seq_ff <= SQ_START;
      gap_ff <= '0;
      flash_cnt_ff <= '0;
      gap_is_pause_ff <= 1'b0;
      fl_start_ff <= 1'b0;
    end else begin
      fl_start_ff <= 1'b0;
      case (seq_ff)
        SQ_START: begin
          // selection only changes here, once per cycle of the pattern
          if (any_fault) begin
            flash_cnt_ff <= (low_code == '0) ? 5'h01 : {1'b0, low_code};
            gap_is_pause_ff <= 1'b1;
          end else begin
            flash_cnt_ff <= 5'h01;
            gap_is_pause_ff <= 1'b0;
          end
          fl_start_ff <= 1'b1;
          seq_ff <= SQ_FLASH;
        end
        SQ_FLASH: begin
          if (!fl_busy && !fl_start_ff) begin
            seq_ff <= SQ_GAP;
            // idle period counts from the start of the single flash
            gap_ff <= gap_is_pause_ff ? PAUSE_CYC - CNT_W'(1)
                    : IDLE_CYC - FLASH_ON_CYC - FLASH_OFF_CYC - CNT_W'(1);
          end
        end
        SQ_GAP: begin
          if (gap_ff == '0) begin
            seq_ff <= SQ_START;
          end else begin
            gap_ff <= gap_ff - CNT_W'(1);
          end
        end
        default: seq_ff <= SQ_START;
      endcase
    end
  end

  fidl_flasher #(
    .CNT_W(CNT_W),
    .ON_CYC(FLASH_ON_CYC),
    .OFF_CYC(FLASH_OFF_CYC)
  ) u_flasher (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(fl_start_ff),
    .count_i(flash_cnt_ff),
    .led_o(fl_led),
    .busy_o(fl_busy)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      led_orange_o <= 1'b0;
    end else begin
      led_orange_o <= fl_led & ~disp_ff;
    end
  end

  // -----------------------------------------------------------------
  // display message select, fixed priority
  // -----------------------------------------------------------------
  logic [3:0] nxt_msg;
  always_comb begin
    nxt_msg = fidl_pkg::MSG_NONE;
    if (fault_flags_o[fidl_pkg::F_SOFTWARE]) nxt_msg = fidl_pkg::MSG_SOFTWARE;
    if (fault_flags_o[fidl_pkg::F_CFG_RANGE]) nxt_msg = fidl_pkg::MSG_CFG_RANGE;
    if (fault_flags_o[fidl_pkg::F_MEASURE]) nxt_msg = fidl_pkg::MSG_MEASURE;
    if (fault_flags_o[fidl_pkg::F_UNSPEC_HW]) nxt_msg = fidl_pkg::MSG_UNSPEC_HW;
    if (fault_flags_o[fidl_pkg::F_INT_TEMP]) nxt_msg = fidl_pkg::MSG_INT_TEMP;
    if (fault_flags_o[fidl_pkg::F_ANALOG_OUT]) nxt_msg = fidl_pkg::MSG_ANALOG_OUT;
    if (fault_flags_o[fidl_pkg::F_MODEM]) nxt_msg = fidl_pkg::MSG_MODEM;
    if (fault_flags_o[fidl_pkg::F_DISPLAY]) nxt_msg = fidl_pkg::MSG_DISPLAY;
    if (fault_flags_o[fidl_pkg::F_MICROWAVE]) nxt_msg = fidl_pkg::MSG_MICROWAVE;
    if (fault_flags_o[fidl_pkg::F_OTHER_MEM]) nxt_msg = fidl_pkg::MSG_OTHER_MEM;
    if (fault_flags_o[fidl_pkg::F_CFG_MEM]) nxt_msg = fidl_pkg::MSG_CFG_MEM;
    if (fault_flags_o[fidl_pkg::F_PROG_MEM]) nxt_msg = fidl_pkg::MSG_PROG_MEM;
    if (fault_flags_o[fidl_pkg::F_DATA_MEM]) nxt_msg = fidl_pkg::MSG_DATA_MEM;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      msg_o <= fidl_pkg::MSG_NONE;
    end else begin
      msg_o <= disp_ff ? nxt_msg : fidl_pkg::MSG_NONE;
    end
  end

  // -----------------------------------------------------------------
  // measurement variable rotation
  // -----------------------------------------------------------------
  logic [CNT_W-1:0] var_tmr_ff;
  logic [3:0] nxt_idx;
  always_comb begin
    nxt_idx = var_idx_o;
    for (int k = NUM_VARS - 1; k >= 1; k--) begin
      // the last index has no mask bit, so it is never selected
      if ((32'(var_idx_o) + k) % NUM_VARS < 8 &&
          var_sel_mask_i[3'((32'(var_idx_o) + k) % NUM_VARS)]) begin
        nxt_idx = 4'((32'(var_idx_o) + k) % NUM_VARS);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      var_tmr_ff <= '0;
      var_idx_o <= 4'h0;
    end else if (var_tmr_ff == VAR_CYC - CNT_W'(1)) begin
      var_tmr_ff <= '0;
      var_idx_o <= nxt_idx;
    end else begin
      var_tmr_ff <= var_tmr_ff + CNT_W'(1);
    end
  end
endmodule // fidl_fault_indicator

// ===== tb/fidl_checker.sv
// Purpose: port-level checks for the fault indicator
// Assumes: flash-on time shortened to 4 cycles in the bench
// Notes: strap is 2-FF synced, so display checks wait 4 cycles
`timescale 1ns/1ps
module fidl_checker (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic has_display_i,
  input wire logic [fidl_pkg::FLT_W-1:0] fault_i,
  input wire logic data_mem_test_err_i,
  input wire logic prog_mem_test_err_i,
  input wire logic cfg_mem_err_i,
  input wire logic cfg_range_err_i,
  input wire logic led_orange_o,
  input wire logic [3:0] msg_o,
  input wire logic [fidl_pkg::FLT_W-1:0] fault_flags_o,
  input wire logic self_reset_o,
  input wire logic use_defaults_o,
  input wire logic [3:0] var_idx_o
);
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence data_flag_s;
    fault_flags_o[0] ##1 self_reset_o;
  endsequence
  sequence prog_flag_s;
    fault_flags_o[1] ##1 self_reset_o;
  endsequence
  led_dark_a: assert property (has_display_i [*4] |-> !led_orange_o)
    else $error("led lit on unit with display");
  msg_none_a: assert property (!has_display_i [*4] |-> msg_o == 4'h0)
    else $error("message shown without display");
  flag_follow_a: assert property (!rst_i |=> fault_flags_o[6] == $past(fault_i[6]))
    else $error("modem flag not merged");
  data_reset_a: assert property (data_mem_test_err_i |=> data_flag_s)
    else $error("data memory error without flag and reset");
  prog_reset_a: assert property (prog_mem_test_err_i |=> prog_flag_s)
    else $error("program memory error without flag and reset");
  reset_hold_a: assert property (self_reset_o |=> self_reset_o)
    else $error("reset request dropped");
  cfg_mem_a: assert property (cfg_mem_err_i |=> use_defaults_o && fault_flags_o[2])
    else $error("config memory error without defaults");
  cfg_range_a: assert property (cfg_range_err_i |=> use_defaults_o && fault_flags_o[14])
    else $error("range error without defaults");
  // strap change may cut a flash short, so it disables this one
  flash_width_a: assert property (disable iff (rst_i || has_display_i)
    $rose(led_orange_o) |-> led_orange_o [*4] ##1 !led_orange_o)
    else $error("flash length wrong");
  var_hold_a: assert property (!$stable(var_idx_o) |=> $stable(var_idx_o) [*8])
    else $error("variable advanced too soon");
endmodule // fidl_checker
bind fidl_fault_indicator fidl_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .has_display_i(has_display_i), .fault_i(fault_i), .data_mem_test_err_i(data_mem_test_err_i),
  .prog_mem_test_err_i(prog_mem_test_err_i), .cfg_mem_err_i(cfg_mem_err_i),
  .cfg_range_err_i(cfg_range_err_i), .led_orange_o(led_orange_o), .msg_o(msg_o),
  .fault_flags_o(fault_flags_o), .self_reset_o(self_reset_o),
  .use_defaults_o(use_defaults_o), .var_idx_o(var_idx_o));

// ===== tb/fidl_operator.sv
// Purpose: operator watching the status led
// Assumes: dark spans of 20 cycles or more separate bursts
// Notes: reports a burst at the next rise, with the dark span after it
`timescale 1ns/1ps
module fidl_operator (
  input wire logic clk_sys_i,
  input wire logic led_i,
  output logic rep_v_o,
  output logic [4:0] rep_cnt_o,
  output logic [7:0] rep_gap_o
);
  logic led_ff = 1'b0;
  logic [4:0] cnt_ff = 5'h00;
  logic [7:0] dark_ff = 8'h00;
  initial rep_v_o = 1'b0;
  always @(posedge clk_sys_i) begin
    led_ff <= led_i;
    rep_v_o <= 1'b0;
    if (led_i && !led_ff) begin
      if (dark_ff >= 8'h14) begin
        rep_v_o <= 1'b1;
        rep_cnt_o <= cnt_ff;
        rep_gap_o <= dark_ff;
        cnt_ff <= 5'h01;
      end else begin
        cnt_ff <= cnt_ff + 5'h01;
      end
    end
    // saturate so a long dark spell never wraps into a short one
    dark_ff <= led_i ? 8'h00 : ((dark_ff == 8'hFF) ? dark_ff : dark_ff + 8'h01);
  end
endmodule // fidl_operator

// ===== tb/fault_indicator_led_lcd_bench.sv
// Purpose: self-checking bench for the fault indicator
// Assumes: shortened counts, pause 50 and idle period 40 cycles
// Notes: led notes are {pause seen, flash count}
`timescale 1ns/1ps
module fault_indicator_led_lcd_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic has_display_i = 1'b0;
  logic [15:0] fault_i = 16'h0000;
  logic dm_err = 1'b0;
  logic pm_err = 1'b0;
  logic cm_err = 1'b0;
  logic cr_err = 1'b0;
  logic [7:0] var_sel_mask_i = 8'h00;
  logic led_orange_o, self_reset_o, use_defaults_o, rep_v;
  logic [3:0] msg_o, var_idx_o;
  logic [15:0] fault_flags_o;
  logic [4:0] rep_cnt;
  logic [7:0] rep_gap;
  logic [5:0] exp_q[$];
  int bad_count = 0;
  int compares = 0;
  int seed = 2;
  int bits[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 11, 12, 14, 15};
  logic [15:0] r;
  always #5 clk_sys_i = ~clk_sys_i;
  fidl_fault_indicator #(.IDLE_CYC(32'h28), .PAUSE_CYC(32'h32), .FLASH_ON_CYC(32'h4),
    .FLASH_OFF_CYC(32'h4), .VAR_CYC(32'h14)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .has_display_i(has_display_i), .fault_i(fault_i), .data_mem_test_err_i(dm_err),
    .prog_mem_test_err_i(pm_err), .cfg_mem_err_i(cm_err), .cfg_range_err_i(cr_err),
    .var_sel_mask_i(var_sel_mask_i), .led_orange_o(led_orange_o), .msg_o(msg_o),
    .fault_flags_o(fault_flags_o), .self_reset_o(self_reset_o),
    .use_defaults_o(use_defaults_o), .var_idx_o(var_idx_o));
  fidl_operator u_op (.clk_sys_i(clk_sys_i), .led_i(led_orange_o), .rep_v_o(rep_v),
    .rep_cnt_o(rep_cnt), .rep_gap_o(rep_gap));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task summarize();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task do_reset();
    rst_i = 1'b1;
    tick(8);
    rst_i = 1'b0;
  endtask
  function automatic logic [5:0] exp_led(logic [15:0] f);
    for (int i = 0; i < 16; i++)
      if (f[i] && fidl_pkg::LED_CODE_MASK[i]) return {1'b1, (i == 0) ? 5'h01 : 5'(i)};
    return 6'h01;
  endfunction
  function automatic logic [3:0] exp_msg(int b);
    case (b)
      8: return 4'hA;
      11: return 4'h9;
      12: return 4'hB;
      14: return 4'hC;
      15: return 4'hD;
      default: return 4'(b + 1);
    endcase
  endfunction
  // next selected variable after index 0, or 0 again when none is selected
  function automatic logic [3:0] exp_var(logic [7:0] m);
    for (int k = 1; k < 8; k++)
      if (m[k]) return 4'(k);
    return 4'h0;
  endfunction
  // selection only changes after a pause or idle gap, so three bursts are let go first
  task led_case(logic [15:0] f);
    fault_i = f;
    repeat (3) @(posedge rep_v);
    tick(2);
    exp_q.push_back(exp_led(f));
    @(posedge rep_v);
    tick(2);
  endtask
  always @(negedge clk_sys_i) begin
    if (rep_v && exp_q.size() > 0)
      chk("flash_pattern", 16'(exp_q.pop_front()), {10'h000, rep_gap >= 8'h32, rep_cnt});
  end
  initial begin
    #500000;
    bad_count++;
    summarize();
  end
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    do_reset();
    chk("flags_after_reset", 16'h0000, fault_flags_o);
    var_sel_mask_i = 8'($random(seed));
    led_case(16'h0000);
    for (int c = 0; c < 16; c++) led_case(16'h0001 << c);
    repeat (4) begin
      r = 16'($random(seed));
      led_case(r);
    end
    $display("test led codes done");
    has_display_i = 1'b1;
    fault_i = 16'h0000;
    do_reset();
    tick(3);
    foreach (bits[i]) begin
      fault_i = 16'h0001 << bits[i];
      tick(4);
      chk("message", {12'h000, exp_msg(bits[i])}, {12'h000, msg_o});
      chk("led_dark", 16'h0000, {15'h0000, led_orange_o});
    end
    fault_i = 16'h0000;
    tick(120);
    $display("test display messages done");
    dm_err = 1'b1;
    tick(1);
    dm_err = 1'b0;
    tick(3);
    chk("data_mem_reset", 16'h0001, {15'h0000, self_reset_o});
    do_reset();
    pm_err = 1'b1;
    tick(1);
    pm_err = 1'b0;
    tick(3);
    chk("prog_mem_reset", 16'h0001, {15'h0000, self_reset_o});
    do_reset();
    cm_err = 1'b1;
    tick(2);
    chk("cfg_mem_flag", 16'h8001, {fault_flags_o[2], 14'h0000, use_defaults_o});
    cm_err = 1'b0;
    cr_err = 1'b1;
    tick(2);
    chk("cfg_range_flag", 16'h4001, {1'b0, fault_flags_o[14], 13'h0000, use_defaults_o});
    cr_err = 1'b0;
    tick(2);
    chk("defaults_cleared", 16'h0000, {15'h0000, use_defaults_o});
    $display("test self-test responses done");
    do_reset();
    tick(20);
    chk("var_index", {12'h000, exp_var(var_sel_mask_i)}, {12'h000, var_idx_o});
    $display("test variable rotation done");
    summarize();
  end
endmodule // fault_indicator_led_lcd_bench
